// File: src/sar_converter_input_control.sv
// Purpose: APB control of selector, gain stage and 10-bit SAR sequencing
// Assumes: comparator pin high when input at or above the trial code
// Notes:   Triggers in shutdown are dropped and sequencing freezes
// Summary of operation
// R1 - Front end powers and holds only while the converter enable bit is set
// R2 - Nine channels: eight external inputs, channel eight is the temperature sensor
// R3 - Each input pair is single-ended or differential, changeable any time
// R4 - Reset returns all input pairs to single-ended
// R5 - Selector controlled by channel select and pair configuration registers
// R6 - Three-bit gain field in the configuration register sets amplification
// R7 - Gains of 0.5, 1, 2, 4, 8 and 16 are available
// R8 - Reset selects unity gain
// R9 - Each conversion yields a 10-bit successive approximation result
// R10 - Converter clock is pclk divided by the divider field plus one, at least four
// R11 - Start mode picks software, timer 3, external edge or timer 2 trigger
// R12 - Busy high during conversion; its fall sets the done flag
// R13 - Result left or right justified in high and low registers
// R14 - In shutdown, triggers ignored; busy, done and result left unchanged
// R15 - Gain codes follow a fixed table with unity reached from reset
`timescale 1ns/100ps
`default_nettype none
module sar_converter_input_control (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  timer2_overflow,
  input  wire logic                  timer3_overflow,
  input  wire logic                  external_convert_start,
  input  wire logic                  comparator_high,
  output logic [sar_pkg::RESULT_W-1:0] sar_dac_code,
  output sar_pkg::analog_ctrl_s      analog_ctrl
);
  import sar_pkg::*;

  typedef enum {ST_IDLE, ST_SAMPLE, ST_CONVERT} conv_state_e;

  // ************************************************************
  // Registers
  // ************************************************************
  logic                 enable_reg, justify_reg, done_reg;
  start_mode_e          mode_reg;
  logic [DIV_W-1:0]     div_reg;
  logic [GAIN_W-1:0]    gain_reg;
  logic [CHANNEL_W-1:0] channel_reg;
  logic [PAIR_W-1:0]    pair_reg;
  logic [RESULT_W-1:0]  result_reg, dac_reg, mask_reg;
  logic [RESULT_W-1:0]  dac_next, mask_next, trial_kept;
  logic [31:0]          rdata_reg;
  conv_state_e          state_reg, state_next;
  logic                 ext_s1, ext_s2, ext_s3, comp_s1, comp_s2;
  logic                 done_next, tick;

  // ************************************************************
  // APB decode
  // ************************************************************
  wire access   = psel && penable;
  wire setup    = psel && !penable;
  wire hit_ctl  = (paddr == ADDR_CONTROL);
  wire hit_cfg  = (paddr == ADDR_CONFIG);
  wire hit_chn  = (paddr == ADDR_CHANNEL);
  wire hit_pair = (paddr == ADDR_PAIR);
  wire hit_rh   = (paddr == ADDR_RES_HIGH);
  wire hit_rl   = (paddr == ADDR_RES_LOW);
  wire mapped   = hit_ctl || hit_cfg || hit_chn || hit_pair || hit_rh || hit_rl;
  wire wr       = access && pwrite && mapped;
  wire wr_ctl   = wr && hit_ctl;
  wire wr_cfg   = wr && hit_cfg;
  wire wr_chn   = wr && hit_chn; // R5
  wire wr_pair  = wr && hit_pair; // R5

  assign pready  = 1'b1;
  assign pslverr = access && !mapped; // R5
  assign prdata  = rdata_reg;

  // ************************************************************
  // Result justification and read mux
  // ************************************************************
  wire [7:0] res_high = justify_reg ? result_reg[RESULT_W-1:RESULT_W-8] // R13
                                    : {{JUST_PAD{1'b0}}, result_reg[RESULT_W-1:8]};
  wire [7:0] res_low  = justify_reg ? {result_reg[RESULT_W-9:0], {JUST_PAD{1'b0}}} // R13
                                    : result_reg[7:0];
  wire busy = (state_reg != ST_IDLE); // R12
  wire [7:0] ctl_view = {enable_reg, 1'b0, done_reg, busy, mode_reg, 1'b0, justify_reg};
  wire [7:0] cfg_view = {div_reg, gain_reg}; // R6
  wire [7:0] rd_mux   = hit_ctl  ? ctl_view :
                        hit_cfg  ? cfg_view :
                        hit_chn  ? {{(8-CHANNEL_W){1'b0}}, channel_reg} :
                        hit_pair ? {{(8-PAIR_W){1'b0}}, pair_reg} :
                        hit_rh   ? res_high :
                        hit_rl   ? res_low  : 8'h00;

  // ************************************************************
  // Trigger selection
  // ************************************************************
  wire ext_rise = ext_s2 && !ext_s3;
  wire sw_start = wr_ctl && pwdata[CTL_BUSY] && (mode_reg == START_SOFTWARE);
  wire trig_sel = (mode_reg == START_SOFTWARE) ? sw_start : // R11
                  (mode_reg == START_TIMER3)   ? timer3_overflow :
                  (mode_reg == START_EXTERNAL) ? ext_rise : timer2_overflow;
  wire start    = enable_reg && trig_sel && (state_reg == ST_IDLE); // R14
  wire step     = enable_reg && tick; // R14
  wire last_bit = (state_reg == ST_CONVERT) && step && mask_reg[0];
  wire [CHANNEL_W-1:0] chn_wr = (pwdata[CHANNEL_W-1:0] > CHANNEL_TEMP) ? CHANNEL_TEMP
                                                                       : pwdata[CHANNEL_W-1:0];

  // ************************************************************
  // SAR sequencing
  // ************************************************************
  assign trial_kept = comp_s2 ? dac_reg : (dac_reg & ~mask_reg); // R9
  assign done_next  = last_bit || (done_reg && !(wr_ctl && !pwdata[CTL_DONE])) || // R12
                      (wr_ctl && pwdata[CTL_DONE]);

  always_comb begin
    state_next = state_reg;
    dac_next   = dac_reg;
    mask_next  = mask_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (step) begin
          state_next = ST_CONVERT;
          mask_next  = {1'b1, {(RESULT_W-1){1'b0}}};
          dac_next   = {1'b1, {(RESULT_W-1){1'b0}}};
        end
      end
      ST_CONVERT: begin
        if (step) begin
          mask_next = mask_reg >> 1; // R9
          dac_next  = trial_kept | (mask_reg >> 1);
          if (mask_reg[0]) begin
            state_next = ST_IDLE;
          end
        end
      end
    endcase
  end

  sar_tick_divider u_sar_tick_divider (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (busy && enable_reg),
    .divide  (div_reg), // R10
    .tick    (tick)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ext_s1, ext_s2, ext_s3, comp_s1, comp_s2} <= '0;
    end else begin
      {ext_s3, ext_s2, ext_s1} <= {ext_s2, ext_s1, external_convert_start};
      {comp_s2, comp_s1}       <= {comp_s1, comparator_high};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg  <= ST_IDLE;
      dac_reg    <= '0;
      mask_reg   <= '0;
      result_reg <= '0;
      done_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      dac_reg   <= dac_next;
      mask_reg  <= mask_next;
      done_reg  <= done_next;
      if (last_bit) begin
        result_reg <= trial_kept; // R9
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg  <= 1'b0;
      justify_reg <= 1'b0;
      mode_reg    <= START_SOFTWARE;
      div_reg     <= DIV_RESET;
      gain_reg    <= GAIN_X1; // R8
      channel_reg <= CHANNEL_RESET;
      pair_reg    <= PAIR_RESET; // R4
      rdata_reg   <= '0;
    end else begin
      if (wr_ctl) begin
        enable_reg  <= pwdata[CTL_ENABLE];
        justify_reg <= pwdata[CTL_JUSTIFY];
        mode_reg    <= start_mode_e'(pwdata[CTL_MODE_LO +: 2]);
      end
      if (wr_cfg) begin
        div_reg  <= pwdata[CFG_DIV_LO +: DIV_W];
        gain_reg <= pwdata[CFG_GAIN_LO +: GAIN_W]; // R6
      end
      if (wr_chn) begin
        channel_reg <= chn_wr; // R2
      end
      if (wr_pair) begin
        pair_reg <= pwdata[PAIR_W-1:0]; // R3
      end
      if (setup) begin
        rdata_reg <= {24'h000000, rd_mux};
      end
    end
  end

  // ************************************************************
  // Analog front end controls
  // ************************************************************
  assign sar_dac_code                = dac_reg;
  assign analog_ctrl.power_on        = enable_reg; // R1
  assign analog_ctrl.hold            = busy && enable_reg; // R1
  assign analog_ctrl.channel         = channel_reg; // R2
  assign analog_ctrl.pair_diff       = pair_reg; // R3
  assign analog_ctrl.gain_half_units = gain_half_units(gain_reg); // R7 R15

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [3:0] tick_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
    end else if (start) begin
      tick_cnt <= '0;
    end else if (step && busy) begin
      tick_cnt <= tick_cnt + 4'h1;
    end
  end

  a_hold_needs_power: assert property (!analog_ctrl.power_on |-> !analog_ctrl.hold) // R1
    else $error("hold active in shutdown");
  a_channel_range: assert property (analog_ctrl.channel <= CHANNEL_TEMP) // R2
    else $error("channel beyond temperature sensor");
  a_pair_write: assert property (wr_pair |=> analog_ctrl.pair_diff == $past(pwdata[3:0])) // R3
    else $error("pair configuration not taken");
  a_pair_reset: assert property ($rose(presetn) |-> pair_reg == PAIR_RESET) // R4
    else $error("pairs not single-ended after reset");
  a_unmapped_err: assert property (access && !mapped |-> pslverr) // R5
    else $error("unmapped access not flagged");
  a_gain_table: assert property ($onehot(analog_ctrl.gain_half_units)) // R7
    else $error("gain outside table");
  a_gain_reset: assert property ($rose(presetn) |-> analog_ctrl.gain_half_units == 6'h02) // R8
    else $error("gain not unity after reset");
  a_conv_ticks: assert property ($fell(busy) |-> tick_cnt == 4'(RESULT_W + 1)) // R9
    else $error("conversion step count wrong");
  a_ext_start: assert property (start && mode_reg == START_EXTERNAL |-> ext_rise ##1 busy) // R11
    else $error("external start not taken");
  a_done_on_fall: assert property ($fell(busy) |-> done_reg) // R12
    else $error("done flag not set at end");
  a_right_justify: assert property (!justify_reg |-> res_high[7:2] == 6'h00) // R13
    else $error("right justified high bits nonzero");
  a_shutdown_frozen: assert property (!enable_reg |=> $stable(result_reg) && $stable(busy)) // R14
    else $error("state moved in shutdown");

  c_conversion: cover property ($fell(busy));
  c_external: cover property (start && mode_reg == START_EXTERNAL);
  c_diff_pair: cover property (wr_pair && pwdata[0]);
  c_left_read: cover property (setup && hit_rh && justify_reg);

endmodule // sar_converter_input_control
`default_nettype wire

// File: src/sar_pkg.sv
// Purpose: Shared constants, types and helpers for the converter input control
// Assumes: 32-bit APB, 10 MHz pclk, one register per aligned word
// Notes:   Gain table maps a 3-bit code to gain expressed in half units
package sar_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] ADDR_CONTROL  = 8'h00;
  localparam logic [7:0] ADDR_CONFIG   = 8'h04;
  localparam logic [7:0] ADDR_CHANNEL  = 8'h08;
  localparam logic [7:0] ADDR_PAIR     = 8'h0c;
  localparam logic [7:0] ADDR_RES_HIGH = 8'h10;
  localparam logic [7:0] ADDR_RES_LOW  = 8'h14;

  // ************************************************************
  // Widths and field positions
  // ************************************************************
  localparam int RESULT_W    = 10;
  localparam int CHANNEL_W   = 4;
  localparam int PAIR_W      = 4;
  localparam int GAIN_W      = 3;
  localparam int DIV_W       = 5;
  localparam int CTL_ENABLE  = 7;
  localparam int CTL_DONE    = 5;
  localparam int CTL_BUSY    = 4;
  localparam int CTL_MODE_LO = 2;
  localparam int CTL_JUSTIFY = 0;
  localparam int CFG_GAIN_LO = 0;
  localparam int CFG_DIV_LO  = 3;
  localparam int JUST_PAD    = 8 - (RESULT_W - 8);

  // ************************************************************
  // Reset values and encodings
  // ************************************************************
  localparam logic [DIV_W-1:0]     DIV_RESET     = 5'h1f;
  localparam logic [CHANNEL_W-1:0] CHANNEL_RESET = 4'h0;
  localparam logic [CHANNEL_W-1:0] CHANNEL_TEMP  = 4'h8;
  localparam logic [PAIR_W-1:0]    PAIR_RESET    = 4'h0;
  localparam logic [GAIN_W-1:0]    GAIN_X1       = 3'h0;
  localparam logic [GAIN_W-1:0]    GAIN_X2       = 3'h1;
  localparam logic [GAIN_W-1:0]    GAIN_X4       = 3'h2;
  localparam logic [GAIN_W-1:0]    GAIN_X8       = 3'h3;
  localparam logic [GAIN_W-1:0]    GAIN_X16      = 3'h4;

  typedef enum logic [1:0] {
    START_SOFTWARE,
    START_TIMER3,
    START_EXTERNAL,
    START_TIMER2
  } start_mode_e;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS     = 100;
  localparam int SAR_MIN_PERIOD_NS = 400;
  localparam int SAR_MIN_DIV       = (SAR_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ************************************************************
  // Carrier for the analog front end
  // ************************************************************
  typedef struct packed {
    logic                 power_on;
    logic                 hold;
    logic [CHANNEL_W-1:0] channel;
    logic [PAIR_W-1:0]    pair_diff;
    logic [5:0]           gain_half_units;
  } analog_ctrl_s;

  // Gain in half units: 1 = x0.5, 2 = x1 ... 32 = x16
  function automatic logic [5:0] gain_half_units(input logic [GAIN_W-1:0] code);
    logic [5:0] g;
    g = 6'h01;
    unique case (code)
      GAIN_X1:  g = 6'h02;
      GAIN_X2:  g = 6'h04;
      GAIN_X4:  g = 6'h08;
      GAIN_X8:  g = 6'h10;
      GAIN_X16: g = 6'h20;
      default:  g = 6'h01;
    endcase
    return g;
  endfunction

endpackage

// File: src/sar_tick_divider.sv
// Purpose: Converter clock enable divided down from pclk
// Assumes: divide field value plus one, never below the SAR minimum
// Notes:   Counter parks at zero while not running
`timescale 1ns/100ps
`default_nettype none
module sar_tick_divider (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      run,
  input  wire logic [sar_pkg::DIV_W-1:0] divide,
  output logic                           tick
);
  import sar_pkg::*;

  logic [DIV_W:0] count_reg;
  logic [DIV_W:0] count_next;
  wire  [DIV_W:0] raw_limit = {1'b0, divide} + {{DIV_W{1'b0}}, 1'b1};
  wire  [DIV_W:0] min_limit = (DIV_W+1)'(SAR_MIN_DIV);
  wire  [DIV_W:0] limit     = (raw_limit < min_limit) ? min_limit : raw_limit;
  wire            wrap      = (count_reg >= limit - (DIV_W+1)'(1));

  assign tick       = run && wrap; // R10
  assign count_next = (!run || wrap) ? '0 : count_reg + (DIV_W+1)'(1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn) // R10
    tick |=> !tick [*3]) else $error("converter clock ticks too close");

endmodule // sar_tick_divider
`default_nettype wire

// File: dv/tb_sar_converter_input_control.sv
// Purpose: Self-checking bench for the converter input control
// Assumes: Zero-wait APB slave, comparator modelled from a target code
// Notes:   Driver queues expected bus results, a monitor compares them
`timescale 1ns/100ps
`default_nettype none
module tb_sar_converter_input_control;
  import sar_pkg::*;

  // ************************************************************
  // Signals
  // ************************************************************
  typedef struct packed {
    logic [32:0] exp;
    logic [32:0] mask;
  } note_s;

  logic                pclk            = 1'b0;
  logic                presetn         = 1'b0;
  logic                psel            = 1'b0;
  logic                penable         = 1'b0;
  logic                pwrite          = 1'b0;
  logic [7:0]          paddr           = 8'h00;
  logic [31:0]         pwdata          = 32'h0;
  logic [2:0]          trig            = 3'h0;
  logic                comparator_high = 1'b0;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic [RESULT_W-1:0] sar_dac_code;
  analog_ctrl_s        analog_ctrl;
  note_s               notes [$];
  int                  miscompares     = 0;
  int                  checked         = 0;
  logic [31:0]         seed            = 32'h30;
  logic [9:0]          target          = 10'h0;
  logic [31:0]         rd;
  logic [31:0]         exp_low;
  logic [5:0]          gtab [8]        = '{6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h01, 6'h01, 6'h01};

  sar_converter_input_control u_sar_converter_input_control (
    .pclk                   (pclk),
    .presetn                (presetn),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .timer2_overflow        (trig[2]),
    .timer3_overflow        (trig[0]),
    .external_convert_start (trig[1]),
    .comparator_high        (comparator_high),
    .sar_dac_code           (sar_dac_code),
    .analog_ctrl            (analog_ctrl)
  );

  // ************************************************************
  // Clock, comparator model and monitor
  // ************************************************************
  always #50 pclk = ~pclk;

  always @(posedge pclk) begin
    comparator_high <= (sar_dac_code <= target);
  end

  always @(posedge pclk) begin
    note_s n;
    if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
      n = notes.pop_front();
      cmp_bus({pslverr, prdata}, n.exp, n.mask);
    end
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    t = t ^ (t << 5);
    return t;
  endfunction

  task automatic tally_and_finish;
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmp_bus(input logic [32:0] got, input logic [32:0] exp, input logic [32:0] mask);
    if (mask != 33'h0) begin
      checked++;
      if (((got ^ exp) & mask) !== 33'h0) begin
        miscompares++;
        $display("wrong value at %0t: got %h expected %h", $time, got & mask, exp);
      end
    end
  endtask

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] exp, input logic [32:0] mask);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    notes.push_back('{exp, mask});
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      miscompares++;
      tally_and_finish();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, {1'b1, 32'h0});
  endtask

  task automatic rdx(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, {1'b0, exp}, {1'b1, 32'hffffffff});
  endtask

  task automatic fire(input logic [1:0] mode);
    @(posedge pclk);
    trig[mode - 2'd1] <= 1'b1;
    @(posedge pclk);
    trig <= 3'h0;
  endtask

  task automatic convert(input logic [1:0] mode, input logic just);
    logic [7:0] ctl;
    int i;
    target = seed[9:0];
    seed = xs(seed);
    ctl = {4'h8, mode, 1'b0, just};
    wr(ADDR_CONFIG, {24'h0, just ? 5'h07 : 5'h03, GAIN_X1});
    wr(ADDR_CONTROL, {24'h0, ctl});
    if (mode == 2'd0) begin
      wr(ADDR_CONTROL, {24'h0, ctl | 8'h10});
    end else begin
      fire(mode);
    end
    repeat (6) @(posedge pclk);
    cmp_val({31'h0, analog_ctrl.hold}, 32'h1);
    apb(1'b0, ADDR_CONTROL, 32'h0, 33'h10, 33'h10);
    repeat (40) @(posedge pclk);
    apb(1'b0, ADDR_CONTROL, 32'h0, {28'h0, just, 4'h0}, 33'h10);
    for (i = 0; i < 60; i++) begin
      apb(1'b0, ADDR_CONTROL, 32'h0, 33'h0, 33'h0);
      if (rd[5] === 1'b1) break;
    end
    if (i == 60) begin
      miscompares++;
      tally_and_finish();
    end
    exp_low = just ? {24'h0, target[1:0], 6'h0} : {24'h0, target[7:0]};
    rdx(ADDR_CONTROL, {24'h0, ctl | 8'h20});
    rdx(ADDR_RES_HIGH, just ? {24'h0, target[9:2]} : {30'h0, target[9:8]});
    rdx(ADDR_RES_LOW, exp_low);
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmp_val({16'h0, analog_ctrl}, {16'h0, 10'h0, 6'h02});
    rdx(ADDR_CONTROL, 32'h0);
    rdx(ADDR_CONFIG, {24'h0, DIV_RESET, GAIN_X1});
    rdx(ADDR_CHANNEL, {28'h0, CHANNEL_RESET});
    rdx(ADDR_PAIR, {28'h0, PAIR_RESET});
    rdx(ADDR_RES_LOW, 32'h0);
    apb(1'b0, 8'h18, 32'h0, {1'b1, 32'h0}, {1'b1, 32'hffffffff});
    for (int g = 0; g < 8; g++) begin
      wr(ADDR_CONFIG, {24'h0, 5'h03, g[2:0]});
      rdx(ADDR_CONFIG, {24'h0, 5'h03, g[2:0]});
      cmp_val({26'h0, analog_ctrl.gain_half_units}, {26'h0, gtab[g]});
    end
    for (int c = 0; c < 16; c++) begin
      wr(ADDR_CHANNEL, c);
      rdx(ADDR_CHANNEL, (c > 8) ? 32'h8 : c);
      cmp_val({28'h0, analog_ctrl.channel}, (c > 8) ? 32'h8 : c);
    end
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_PAIR, {28'h0, seed[3:0]});
      rdx(ADDR_PAIR, {28'h0, seed[3:0]});
      cmp_val({28'h0, analog_ctrl.pair_diff}, {28'h0, seed[3:0]});
      seed = xs(seed);
    end
    for (int m = 0; m < 4; m++) begin
      convert(m[1:0], m[0]);
    end
    wr(ADDR_RES_LOW, 32'hff);
    rdx(ADDR_RES_LOW, exp_low);
    wr(ADDR_CONTROL, 32'h2d);
    fire(2'd3);
    repeat (10) @(posedge pclk);
    rdx(ADDR_CONTROL, 32'h2d);
    rdx(ADDR_RES_LOW, exp_low);
    cmp_val({30'h0, analog_ctrl.power_on, analog_ctrl.hold}, 32'h0);
    wr(ADDR_CONTROL, 32'h01);
    rdx(ADDR_CONTROL, 32'h01);
    tally_and_finish();
  end

endmodule // tb_sar_converter_input_control
`default_nettype wire
